// file: sbc_params.svh
// standby entry control: register layout, reset values and field positions
// assumes inclusion by the standby controller package, its modules and its bench
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_ADDR_CTRL      8'h14
`define SBC_ADDR_STATUS    8'h18
`define SBC_CTRL_RESET     8'h1f
`define SBC_CTRL_RO_MASK   8'h1f
`define SBC_BIT_SELECT     7
`define SBC_BIT_FLOAT      6
`define SBC_WDT_CLR_MASK   8'he0
`define SBC_WDT_KEEP_MASK  8'h07
`define SBC_STROBE_CYCLES  4'h2

`endif

// file: sbc_pkg.sv
// standby entry control: shared types
// assumes the params header sits in the same folder
package sbc_pkg;
    `include "sbc_params.svh"

    // one entry for each peripheral group told to act on standby entry
    typedef struct packed {
        logic data_transfer;   // all registers except the transfer data register
        logic dma_ctrl;        // channel control regs and operation reg
        logic dma_undefined;   // source, dest and count regs become undefined
        logic wdt_partial;     // bits 7..5 of watchdog ctrl/status, reset ctrl reg
        logic serial;          // rx, tx, mode, control, status, bit-rate regs
        logic multifunction_timer_unit;             // multifunction timer, output enable regs kept
        logic compare_match_timer_unit;             // compare match timer
        logic adc;             // analog-to-digital converter
    } sbc_init_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sbc_bus_req_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_INIT,
        ST_STANDBY
    } sbc_state_t;
endpackage

// file: sbc_init_pulse.sv
// standby entry control: stretcher for the peripheral initialise strobes
// assumes a synchronous active high reset and a single start pulse
`timescale 1ns/100ps
`include "sbc_params.svh"
module sbc_init_pulse
    import sbc_pkg::*;
#(
    parameter logic [3:0] CYCLES = `SBC_STROBE_CYCLES
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       done;
    } sbc_pulse_st_t;

    sbc_pulse_st_t st_r;
    sbc_pulse_st_t st_nxt;

    // count down the strobe width, flag done once in the cycle after the last
    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.cnt = CYCLES;
        end else if (st_r.cnt != 4'h0) begin
            st_nxt.cnt = st_r.cnt - 4'h1;
            st_nxt.done = (st_r.cnt == 4'h1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy = (st_r.cnt != 4'h0);
    assign done = st_r.done;
endmodule

// file: sbc_standby_ctrl.sv
// standby entry control: control register, standby sequencing and outputs
// assumes the cpu pulses halt_exec on its halt instruction, nmi and manual
// reset come from pins, watchdog enable comes from on-chip logic
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "sbc_params.svh"

// Notes on behaviour
// - with the select bit set, a halt instruction moves the device from running into standby.
// - in standby the cpu is stopped, the system clock gated and every peripheral halted.
// - cpu registers and ram are kept, so no clear reaches them during standby.
// - in standby the port pads either hold their state or float, as the float bit chooses.
// - only chosen peripherals are cleared; interrupt, break, cache and bus units keep everything.
// - the data transfer unit is initialised but its memory data and transfer data register are kept.
// - watchdog bits 7..5 and its reset control register are cleared; clock select and counter are kept.
// - the serial rx, tx, mode, control, status and bit-rate registers are initialised.
// - neither the select bit nor the float bit can be set to 1 while the watchdog timer runs.
// - a float bit of 0 holds the pads, 1 floats them during standby.
// - the control register resets to 0x1f with select and float clear and the low bits read as one.
// - standby ends only on an nmi edge, a power-on reset or a manual reset.
module sbc_standby_ctrl
    import sbc_pkg::*;
(
    // clock and power-on reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [7:0]        reg_rdata,
    // cpu side
    input  wire logic         halt_exec,
    input  wire logic         wdt_enable,
    output logic              cpu_stop,
    output logic              sleep_mode,
    // wake sources from pins
    input  wire logic         nmi_pin,
    input  wire logic         nmi_rise_sel,
    input  wire logic         manual_rst_n,
    // clock and peripheral control
    output logic              sys_clk_gate,
    output logic              periph_halt,
    output sbc_init_t         periph_init,
    output logic [7:0]        wdt_clear_mask,
    output logic [7:0]        wdt_keep_mask,
    // port pads
    output logic              pad_hold,
    output logic              pad_oe_n_force
);
    typedef struct packed {
        sbc_state_t  state;
        logic        sel;
        logic        flt;
        logic [7:0]  rdata;
        logic [1:0]  nmi_sync;
        logic [1:0]  mrst_sync;
        logic        nmi_prev;
        logic        sleep;
    } sbc_st_t;

    sbc_st_t      st_r;
    sbc_st_t      st_nxt;
    sbc_bus_req_t bus;
    logic         init_busy;
    logic         init_done;
    logic         init_start;
    logic         nmi_edge;
    logic         mrst_active;
    logic [7:0]   ctrl_view;

    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;

    // register view: reserved bit 5 reads 0, bits 4..0 read 1
    function automatic logic [7:0] ctrl_value(input logic sel, input logic flt);
        logic [7:0] v;
        v = `SBC_CTRL_RESET;
        v[`SBC_BIT_SELECT] = sel;
        v[`SBC_BIT_FLOAT]  = flt;
        return v;
    endfunction

    assign ctrl_view = ctrl_value(st_r.sel, st_r.flt);

    // edge is taken only from the second synchroniser stage onward
    assign nmi_edge    = nmi_rise_sel ? (st_r.nmi_sync[1] & ~st_r.nmi_prev)
                                      : (~st_r.nmi_sync[1] & st_r.nmi_prev);
    assign mrst_active = ~st_r.mrst_sync[1];
    assign init_start  = (st_r.state == ST_RUN) && halt_exec && st_r.sel;

    sbc_init_pulse #(
        .CYCLES (`SBC_STROBE_CYCLES)
    ) u_pulse (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (init_start),
        .busy    (init_busy),
        .done    (init_done)
    );

    // next state: register writes, sequencing, wake detection
    always_comb begin
        st_nxt           = st_r;
        st_nxt.nmi_sync  = {st_r.nmi_sync[0], nmi_pin};
        st_nxt.mrst_sync = {st_r.mrst_sync[0], manual_rst_n};
        st_nxt.nmi_prev  = st_r.nmi_sync[1];
        st_nxt.rdata     = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `SBC_ADDR_CTRL:   st_nxt.rdata = ctrl_view;
                `SBC_ADDR_STATUS: st_nxt.rdata = {5'h00, st_r.sleep, st_r.state};
                default:          st_nxt.rdata = 8'h00;
            endcase
        end
        // a running watchdog blocks setting either bit; clearing always works
        if (bus.wr && bus.addr == `SBC_ADDR_CTRL) begin
            st_nxt.sel = bus.wdata[`SBC_BIT_SELECT] & ~(wdt_enable & ~st_r.sel);
            st_nxt.flt = bus.wdata[`SBC_BIT_FLOAT] & ~(wdt_enable & ~st_r.flt);
        end
        case (st_r.state)
            ST_RUN: begin
                if (halt_exec && st_r.sel) begin
                    st_nxt.state = ST_INIT;
                end else if (halt_exec) begin
                    st_nxt.sleep = 1'b1;
                end else if (st_r.sleep && (nmi_edge || mrst_active)) begin
                    st_nxt.sleep = 1'b0;
                end
            end
            ST_INIT: begin
                if (init_done) begin
                    st_nxt.state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                // only nmi edge or manual reset wake; power-on reset is rst
                if (nmi_edge || mrst_active) begin
                    st_nxt.state = ST_RUN;
                end
            end
            default: st_nxt.state = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r           <= '0;
            st_r.state     <= ST_RUN;
            st_r.nmi_sync  <= 2'b00;
            st_r.mrst_sync <= 2'b11;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata  = st_r.rdata;
    assign sleep_mode = st_r.sleep;

    // cpu halts in init too, so its registers stay put; nothing clears them
    assign cpu_stop     = (st_r.state != ST_RUN) || st_r.sleep;
    assign sys_clk_gate = (st_r.state == ST_STANDBY);
    assign periph_halt  = (st_r.state == ST_STANDBY);

    // pads: hold when float bit 0, release drivers when 1
    assign pad_hold       = (st_r.state != ST_RUN) && !st_r.flt;
    assign pad_oe_n_force = (st_r.state != ST_RUN) && st_r.flt;

    // strobes only for the listed groups; interrupt_controller_unit, break, cache, bus units get none
    always_comb begin
        periph_init               = '0;
        periph_init.data_transfer = init_busy;
        periph_init.dma_ctrl      = init_busy;
        periph_init.dma_undefined = init_busy;
        periph_init.wdt_partial   = init_busy;
        periph_init.serial        = init_busy;
        periph_init.multifunction_timer_unit           = init_busy;
        periph_init.compare_match_timer_unit           = init_busy;
        periph_init.adc           = init_busy;
    end

    assign wdt_clear_mask = init_busy ? `SBC_WDT_CLR_MASK : 8'h00;
    assign wdt_keep_mask  = `SBC_WDT_KEEP_MASK;

    sequence s_enter;
        (st_r.state == ST_RUN) && halt_exec && st_r.sel;
    endsequence

    sequence s_init_then_standby;
        (st_r.state == ST_INIT) [*3] ##1 (st_r.state == ST_STANDBY);
    endsequence

    chk_entry_sequence: assert property (@(posedge ref_clk) disable iff (rst)
        s_enter |=> s_init_then_standby)
        else $error("standby entry did not follow init strobe");

    chk_clock_gated: assert property (@(posedge ref_clk) disable iff (rst)
        (st_r.state == ST_STANDBY) |-> (sys_clk_gate && periph_halt && cpu_stop))
        else $error("clock or peripherals running in standby");

    chk_cpu_stopped_init: assert property (@(posedge ref_clk) disable iff (rst)
        init_busy |-> cpu_stop)
        else $error("cpu not stopped while peripherals initialise");

    chk_pad_mode: assert property (@(posedge ref_clk) disable iff (rst)
        (st_r.state == ST_STANDBY) |-> (pad_hold != pad_oe_n_force) && (pad_oe_n_force == st_r.flt))
        else $error("pad state does not follow float bit");

    chk_init_width: assert property (@(posedge ref_clk) disable iff (rst)
        s_enter |=> periph_init.serial [*2] ##1 !periph_init.serial)
        else $error("init strobe width wrong");

    chk_wdt_mask: assert property (@(posedge ref_clk) disable iff (rst)
        periph_init.wdt_partial |-> (wdt_clear_mask == 8'he0) && (wdt_keep_mask == 8'h07))
        else $error("watchdog masks wrong during init");

    chk_select_blocked: assert property (@(posedge ref_clk) disable iff (rst)
        (bus.wr && bus.addr == `SBC_ADDR_CTRL && wdt_enable && !st_r.sel) |=> !st_r.sel)
        else $error("select bit set while watchdog runs");

    chk_reset_view: assert property (@(posedge ref_clk)
        $fell(rst) |-> (ctrl_view == 8'h1f))
        else $error("control register reset value wrong");

    chk_wake_only: assert property (@(posedge ref_clk) disable iff (rst)
        (st_r.state == ST_STANDBY && !nmi_edge && !mrst_active) |=> (st_r.state == ST_STANDBY))
        else $error("standby left without wake source");
endmodule

// file: sbc_periph_model.sv
// standby entry control: far-side model of the watchdog control register
// assumes the controller's init strobe and masks share the bench clock
`timescale 1ns/100ps
module sbc_periph_model
    import sbc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // software load of the watchdog register
    input  wire logic       wdt_load,
    input  wire logic [7:0] wdt_load_val,
    // controller side
    input  wire sbc_init_t  periph_init,
    input  wire logic [7:0] wdt_clear_mask,
    input  wire logic [7:0] wdt_keep_mask,
    output logic            wdt_enable,
    output logic [7:0]      wdt_reg
);
    // only masked bits clear, so the clock select field survives entry
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdt_reg <= 8'h00;
        end else if (wdt_load) begin
            wdt_reg <= wdt_load_val;
        end else if (periph_init.wdt_partial) begin
            wdt_reg <= wdt_reg & (wdt_keep_mask | ~wdt_clear_mask);
        end
    end
    assign wdt_enable = wdt_reg[5]; // timer enable guards the set of select and float
endmodule

// file: testbench.sv
// standby entry control: self-checking bench over the register port
// assumes the controller and the watchdog model share one 100 MHz clock
`timescale 1ns/100ps
`include "sbc_params.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin $display("CHECK FAILED %s exp %h got %h", nm, exp, got); errors++; end end
module testbench
    import sbc_pkg::*;
;
    logic       ref_clk, rst, reg_wr, reg_rd, halt_exec, nmi_pin, nmi_rise_sel, manual_rst_n, wdt_load, wdt_enable;
    logic       cpu_stop, sleep_mode, sys_clk_gate, periph_halt, pad_hold, pad_oe_n_force;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, wdt_load_val, wdt_clear_mask, wdt_keep_mask, wdt_reg;
    sbc_init_t  periph_init;
    int         errors, compares, cyc;

    sbc_standby_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .wdt_enable(wdt_enable),
        .cpu_stop(cpu_stop), .sleep_mode(sleep_mode), .nmi_pin(nmi_pin), .nmi_rise_sel(nmi_rise_sel),
        .manual_rst_n(manual_rst_n), .sys_clk_gate(sys_clk_gate), .periph_halt(periph_halt),
        .periph_init(periph_init), .wdt_clear_mask(wdt_clear_mask), .wdt_keep_mask(wdt_keep_mask),
        .pad_hold(pad_hold), .pad_oe_n_force(pad_oe_n_force));
    sbc_periph_model peer (.ref_clk(ref_clk), .rst(rst), .wdt_load(wdt_load), .wdt_load_val(wdt_load_val),
        .periph_init(periph_init), .wdt_clear_mask(wdt_clear_mask), .wdt_keep_mask(wdt_keep_mask),
        .wdt_enable(wdt_enable), .wdt_reg(wdt_reg));

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard: the whole sequence needs under a hundred cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK("reg_rdata", exp, reg_rdata)
    endtask

    task automatic wdt_set(input logic [7:0] v);
        @(posedge ref_clk);
        wdt_load     <= 1'b1;
        wdt_load_val <= v;
        @(posedge ref_clk);
        wdt_load     <= 1'b0;
    endtask

    // halt pulse, init strobe for two cycles, one cycle for the done flag, then standby
    task automatic enter_standby(input logic flt);
        @(posedge ref_clk);
        halt_exec <= 1'b1;
        @(posedge ref_clk);
        halt_exec <= 1'b0;
        #1;
        `CHK("periph_init", 8'hff, periph_init)
        `CHK("cpu_stop", 1'b1, cpu_stop)
        `CHK("wdt_clear_mask", 8'he0, wdt_clear_mask)
        `CHK("pad_oe_n_force", flt, pad_oe_n_force)
        `CHK("pad_hold", ~flt, pad_hold)
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("periph_init_off", 8'h00, periph_init)
        `CHK("sys_clk_gate", 1'b1, sys_clk_gate)
        `CHK("periph_halt", 1'b1, periph_halt)
    endtask

    // wake latency is a few cycles of pin synchronisation
    task automatic expect_wake();
        int n;
        for (n = 0; n < 8 && cpu_stop !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK("cpu_stop_wake", 1'b0, cpu_stop)
        `CHK("sys_clk_gate_wake", 1'b0, sys_clk_gate)
    endtask

    initial begin
        {reg_wr, reg_rd, halt_exec, nmi_pin, wdt_load} = '0;
        {reg_addr, reg_wdata, wdt_load_val} = '0;
        nmi_rise_sel = 1'b1;
        manual_rst_n = 1'b1;
        rst          = 1'b1;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        reg_check(`SBC_ADDR_CTRL, 8'h1f);
        reg_check(8'h40, 8'h00);
        `CHK("wdt_keep_mask", 8'h07, wdt_keep_mask)
        // watchdog running: both bits refuse the set
        wdt_set(8'h27);
        reg_write(`SBC_ADDR_CTRL, 8'hdf);
        reg_check(`SBC_ADDR_CTRL, 8'h1f);
        // watchdog stopped, overflow flag left set for the entry clear
        wdt_set(8'h87);
        reg_write(`SBC_ADDR_CTRL, 8'hc0);
        reg_check(`SBC_ADDR_CTRL, 8'hdf);
        // nmi sits high on entry, so the wrong-polarity edge comes first
        nmi_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        enter_standby(1'b1);
        `CHK("wdt_reg", 8'h07, wdt_reg)
        // a falling edge must not wake with rising edge selected
        nmi_pin <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK("cpu_stop_wrong_edge", 1'b1, cpu_stop)
        nmi_pin <= 1'b1;
        expect_wake();
        reg_write(`SBC_ADDR_CTRL, 8'h80);
        reg_check(`SBC_ADDR_CTRL, 8'h9f);
        enter_standby(1'b0);
        @(posedge ref_clk);
        manual_rst_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        manual_rst_n <= 1'b1;
        expect_wake();
        reg_write(`SBC_ADDR_CTRL, 8'h00);
        reg_check(`SBC_ADDR_CTRL, 8'h1f);
        // halt with the select bit clear only sleeps; a falling nmi edge ends it
        nmi_rise_sel <= 1'b0;
        @(posedge ref_clk);
        halt_exec <= 1'b1;
        @(posedge ref_clk);
        halt_exec <= 1'b0;
        #1;
        `CHK("sleep_mode", 1'b1, sleep_mode)
        `CHK("sys_clk_gate_sleep", 1'b0, sys_clk_gate)
        reg_check(`SBC_ADDR_STATUS, 8'h04);
        nmi_pin <= 1'b0;
        expect_wake();
        `CHK("sleep_mode_wake", 1'b0, sleep_mode)
        wrap_up();
    end
endmodule
